// ==== ctrs_exec.sv ====
/*
  Execution of stack/index transfers, interrupt and subroutine returns,
  wait and 20-bit jumps. Assumes the decoder holds OP_* stable while
  OP_VALID is high until OP_READY, and the stack memory answers a held
  MEM_RD_REQ with one MEM_RD_VALID pulse.
*/
// What this block does
// - Stack-to-X copy writes stack value plus two into X.
// - Stack-to-Y copy writes stack value plus two into Y.
// - X-to-stack copy loads stack pointer with X minus two.
// - Y-to-stack copy loads stack pointer with Y minus two.
// - X-to-Y copy moves X extension field with the address.
// - Y-to-X copy moves Y extension field with the address.
// - Interrupt return reloads only program counter, condition codes and stack pointer.
// - Subroutine return pops two 16-bit words for the return location.
// - Wait suspends with no timeout until interrupt or reset.
// - Jump and call use 20-bit indexed and 20-bit extended addressing.
// - Restored condition codes take all sixteen stacked bits.
`timescale 1ns/1ps
`include "ctrs_regs.svh"

module ctrs_exec
  import ctrs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic OP_VALID,
  input wire ctrs_op_e OP_CODE,
  input wire ctrs_mode_e OP_MODE,
  input wire ctrs_base_e OP_BASE,
  input wire ctrs_addr_t OP_OPERAND,
  input wire ctrs_addr_t SP_CUR,
  input wire ctrs_addr_t X_CUR,
  input wire ctrs_addr_t Y_CUR,
  input wire ctrs_addr_t Z_CUR,
  input wire logic IRQ_PEND,
  input wire ctrs_word_t MEM_RD_DATA,
  input wire logic MEM_RD_VALID,
  output logic OP_READY,
  output logic MEM_RD_REQ,
  output ctrs_addr_t MEM_RD_ADDR,
  output logic WAITING,
  output logic X_WR,
  output ctrs_addr_t X_WR_DATA,
  output logic Y_WR,
  output ctrs_addr_t Y_WR_DATA,
  output logic SP_WR,
  output ctrs_addr_t SP_WR_DATA,
  output logic CCR_WR,
  output ctrs_word_t CCR_WR_DATA,
  output logic PC_WR,
  output ctrs_addr_t PC_WR_DATA,
  output logic CALL_STROBE
);

  // =====================================================================
  // Jump target
  function automatic ctrs_addr_t ctrs_target(input ctrs_mode_e mode, input ctrs_base_e base,
                                             input ctrs_addr_t off, input ctrs_addr_t bx,
                                             input ctrs_addr_t by, input ctrs_addr_t bz);
    ctrs_addr_t b;
    b = (base == CTRS_BASE_Y) ? by : (base == CTRS_BASE_Z) ? bz : bx;
    if (mode == CTRS_EXTENDED_20BIT_MODE)
      return off;
    return b + off;
  endfunction : ctrs_target

  ctrs_state_s cur_r;
  ctrs_state_s cur_nxt;
  ctrs_adj_if adj ();
  logic take;
  logic got;

  ctrs_adj20 u_adj (
    .adj (adj.unit)
  );

  // Handshake outputs
  assign OP_READY = (cur_r.st == CTRS_ST_IDLE);
  assign take = OP_VALID && OP_READY;
  assign MEM_RD_REQ = (cur_r.st == CTRS_ST_POP1) || (cur_r.st == CTRS_ST_POP2);
  assign MEM_RD_ADDR = cur_r.sp;
  assign got = MEM_RD_REQ && MEM_RD_VALID;
  assign WAITING = (cur_r.st == CTRS_ST_WAIT);

  // Registered data outputs
  assign X_WR = cur_r.x_wr;
  assign X_WR_DATA = cur_r.x_d;
  assign Y_WR = cur_r.y_wr;
  assign Y_WR_DATA = cur_r.y_d;
  assign SP_WR = cur_r.sp_wr;
  assign SP_WR_DATA = cur_r.sp_d;
  assign CCR_WR = cur_r.ccr_wr;
  assign CCR_WR_DATA = cur_r.ccr_d;
  assign PC_WR = cur_r.pc_wr;
  assign PC_WR_DATA = cur_r.pc_d;
  assign CALL_STROBE = cur_r.call;

  // =====================================================================
  // Adjuster operand selection
  always_comb
  begin
    adj.value = cur_r.sp;
    adj.dec = 1'b0;
    if (cur_r.st == CTRS_ST_IDLE)
    begin
      case (OP_CODE)
        CTRS_OP_STACK_TO_X_COPY, CTRS_OP_STACK_TO_Y_COPY: adj.value = SP_CUR;
        CTRS_OP_X_TO_STACK_COPY:
        begin
          adj.value = X_CUR;
          adj.dec = 1'b1;
        end
        CTRS_OP_Y_TO_STACK_COPY:
        begin
          adj.value = Y_CUR;
          adj.dec = 1'b1;
        end
        default: adj.value = cur_r.sp;
      endcase
    end
  end

  // =====================================================================
  // Next state
  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.x_wr = 1'b0;
    cur_nxt.y_wr = 1'b0;
    cur_nxt.sp_wr = 1'b0;
    cur_nxt.ccr_wr = 1'b0;
    cur_nxt.pc_wr = 1'b0;
    cur_nxt.call = 1'b0;
    case (cur_r.st)
      CTRS_ST_IDLE:
      begin
        if (take)
        begin
          cur_nxt.op = OP_CODE;
          case (OP_CODE)
            CTRS_OP_STACK_TO_X_COPY:
            begin
              cur_nxt.x_wr = 1'b1;
              cur_nxt.x_d = adj.result;
            end
            CTRS_OP_STACK_TO_Y_COPY:
            begin
              cur_nxt.y_wr = 1'b1;
              cur_nxt.y_d = adj.result;
            end
            CTRS_OP_X_TO_STACK_COPY, CTRS_OP_Y_TO_STACK_COPY:
            begin
              cur_nxt.sp_wr = 1'b1;
              cur_nxt.sp_d = adj.result;
            end
            CTRS_OP_X_TO_Y_COPY:
            begin
              cur_nxt.y_wr = 1'b1;
              cur_nxt.y_d = X_CUR;
            end
            CTRS_OP_Y_TO_X_COPY:
            begin
              cur_nxt.x_wr = 1'b1;
              cur_nxt.x_d = Y_CUR;
            end
            CTRS_OP_INTERRUPT_RETURN, CTRS_OP_SUB_RETURN:
            begin
              cur_nxt.sp = SP_CUR;
              cur_nxt.st = CTRS_ST_POP1;
            end
            CTRS_OP_WAIT_FOR_IRQ: cur_nxt.st = IRQ_PEND ? CTRS_ST_IDLE : CTRS_ST_WAIT;
            CTRS_OP_JUMP_OP, CTRS_OP_CALL_OP:
            begin
              cur_nxt.pc_wr = 1'b1;
              cur_nxt.pc_d = ctrs_target(OP_MODE, OP_BASE, OP_OPERAND, X_CUR, Y_CUR, Z_CUR);
              cur_nxt.call = (OP_CODE == CTRS_OP_CALL_OP);
            end
            default: cur_nxt.st = CTRS_ST_IDLE;
          endcase
        end
      end
      CTRS_ST_POP1:
      begin
        if (got)
        begin
          cur_nxt.w1 = MEM_RD_DATA;
          cur_nxt.sp = adj.result;
          cur_nxt.st = CTRS_ST_POP2;
        end
      end
      CTRS_ST_POP2:
      begin
        if (got)
        begin
          cur_nxt.sp = adj.result;
          cur_nxt.sp_wr = 1'b1;
          cur_nxt.sp_d = adj.result;
          cur_nxt.pc_wr = 1'b1;
          cur_nxt.pc_d = {cur_r.w1[`CTRS_PK_MSB:`CTRS_PK_LSB], MEM_RD_DATA};
          cur_nxt.st = CTRS_ST_IDLE;
          if (cur_r.op == CTRS_OP_INTERRUPT_RETURN)
          begin
            cur_nxt.ccr_wr = 1'b1;
            cur_nxt.ccr_d = cur_r.w1;
          end
        end
      end
      CTRS_ST_WAIT:
      begin
        if (IRQ_PEND)
          cur_nxt.st = CTRS_ST_IDLE;
      end
      default: cur_nxt.st = CTRS_ST_IDLE;
    endcase
  end

  // =====================================================================
  // State register
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  property p_sx;
    take && OP_CODE == CTRS_OP_STACK_TO_X_COPY |=> X_WR && X_WR_DATA == 20'($past(SP_CUR) + `CTRS_ADJ_STEP);
  endproperty
  a_sx: assert property (p_sx) else $error("stack to X not plus two");
  property p_sy;
    take && OP_CODE == CTRS_OP_STACK_TO_Y_COPY |=> Y_WR && !X_WR && Y_WR_DATA == 20'($past(SP_CUR) + `CTRS_ADJ_STEP);
  endproperty
  a_sy: assert property (p_sy) else $error("stack to Y not plus two");
  property p_xs;
    take && OP_CODE == CTRS_OP_X_TO_STACK_COPY |=> SP_WR && SP_WR_DATA == 20'($past(X_CUR) - `CTRS_ADJ_STEP);
  endproperty
  a_xs: assert property (p_xs) else $error("X to stack not minus two");
  property p_ys;
    take && OP_CODE == CTRS_OP_Y_TO_STACK_COPY |=> SP_WR && SP_WR_DATA == 20'($past(Y_CUR) - `CTRS_ADJ_STEP);
  endproperty
  a_ys: assert property (p_ys) else $error("Y to stack not minus two");
  property p_xy;
    take && OP_CODE == CTRS_OP_X_TO_Y_COPY |=> Y_WR && Y_WR_DATA == $past(X_CUR);
  endproperty
  a_xy: assert property (p_xy) else $error("X to Y lost extension");
  property p_yx;
    take && OP_CODE == CTRS_OP_Y_TO_X_COPY |=> X_WR && X_WR_DATA == $past(Y_CUR);
  endproperty
  a_yx: assert property (p_yx) else $error("Y to X lost extension");
  property p_ret_only;
    !OP_READY |=> !X_WR && !Y_WR;
  endproperty
  a_ret_only: assert property (p_ret_only) else $error("return reloaded an index");
  property p_frame;
    got && cur_r.st == CTRS_ST_POP2 |=> PC_WR && SP_WR && SP_WR_DATA == 20'($past(MEM_RD_ADDR) + `CTRS_ADJ_STEP)
      && PC_WR_DATA[`CTRS_WORD_W-1:0] == $past(MEM_RD_DATA);
  endproperty
  a_frame: assert property (p_frame) else $error("return frame not two words");
  property p_ccr;
    got && cur_r.st == CTRS_ST_POP2 && cur_r.op == CTRS_OP_INTERRUPT_RETURN
      |=> CCR_WR && CCR_WR_DATA == $past(cur_r.w1);
  endproperty
  a_ccr: assert property (p_ccr) else $error("condition codes not fully restored");
  property p_wait;
    WAITING && !IRQ_PEND |=> WAITING;
  endproperty
  a_wait: assert property (p_wait) else $error("wait ended without interrupt");
  property p_ext;
    take && OP_CODE == CTRS_OP_JUMP_OP && OP_MODE == CTRS_EXTENDED_20BIT_MODE
      |=> PC_WR && PC_WR_DATA == $past(OP_OPERAND);
  endproperty
  a_ext: assert property (p_ext) else $error("extended jump target wrong");
  property p_borrow;
    take && OP_CODE == CTRS_OP_X_TO_STACK_COPY && X_CUR[`CTRS_WORD_W-1:0] == `CTRS_WORD_ZERO
      |=> SP_WR_DATA[`CTRS_ADDR_W-1:`CTRS_WORD_W] == 4'($past(X_CUR[`CTRS_ADDR_W-1:`CTRS_WORD_W]) - 4'h1);
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow not into extension");
  property p_cv_rti;
    cur_r.op == CTRS_OP_INTERRUPT_RETURN && CCR_WR;
  endproperty
  c_cv_rti: cover property (p_cv_rti);
  property p_cv_wait;
    WAITING ##1 !WAITING;
  endproperty
  c_cv_wait: cover property (p_cv_wait);
  property p_cv_call;
    CALL_STROBE && PC_WR;
  endproperty
  c_cv_call: cover property (p_cv_call);

endmodule : ctrs_exec

// ==== ctrs_regs.svh ====
/*
  Constants of the transfer/return execution block: widths, the stack
  adjustment step and the field positions within stacked words.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef CTRS_REGS_SVH
`define CTRS_REGS_SVH

// =====================================================================
// Widths
`define CTRS_ADDR_W 20
`define CTRS_WORD_W 16
`define CTRS_EXT_W 4

// =====================================================================
// Adjustment and field positions
`define CTRS_ADJ_STEP 20'h0_0002
`define CTRS_ADDR_ZERO 20'h0_0000
`define CTRS_WORD_ZERO 16'h0000
`define CTRS_PK_LSB 0
`define CTRS_PK_MSB 3

`endif

// ==== ctrs_pkg.sv ====
/*
  Types of the transfer/return execution block: operations, addressing
  modes, index base selection, sequencer states and the state record.
  Assumes ctrs_regs.svh is on the include path.
*/
`include "ctrs_regs.svh"

package ctrs_pkg;

  // =====================================================================
  // Operation and mode types
  typedef enum logic [3:0] {
    CTRS_OP_NONE = 4'h0,
    CTRS_OP_STACK_TO_X_COPY = 4'h1,
    CTRS_OP_STACK_TO_Y_COPY = 4'h2,
    CTRS_OP_X_TO_STACK_COPY = 4'h3,
    CTRS_OP_Y_TO_STACK_COPY = 4'h4,
    CTRS_OP_X_TO_Y_COPY = 4'h5,
    CTRS_OP_Y_TO_X_COPY = 4'h6,
    CTRS_OP_INTERRUPT_RETURN = 4'h7,
    CTRS_OP_SUB_RETURN = 4'h8,
    CTRS_OP_WAIT_FOR_IRQ = 4'h9,
    CTRS_OP_JUMP_OP = 4'hA,
    CTRS_OP_CALL_OP = 4'hB
  } ctrs_op_e;

  typedef enum logic {
    CTRS_INDEXED_20BIT_MODE = 1'b0,
    CTRS_EXTENDED_20BIT_MODE = 1'b1
  } ctrs_mode_e;

  typedef enum logic [1:0] {
    CTRS_BASE_X = 2'h0,
    CTRS_BASE_Y = 2'h1,
    CTRS_BASE_Z = 2'h2
  } ctrs_base_e;

  // Gray along idle -> pop1 -> pop2, wait beside idle
  typedef enum logic [1:0] {
    CTRS_ST_IDLE = 2'b00,
    CTRS_ST_POP1 = 2'b01,
    CTRS_ST_POP2 = 2'b11,
    CTRS_ST_WAIT = 2'b10
  } ctrs_state_e;

  typedef logic [`CTRS_ADDR_W-1:0] ctrs_addr_t;
  typedef logic [`CTRS_WORD_W-1:0] ctrs_word_t;

  // =====================================================================
  // Whole module state
  typedef struct packed {
    ctrs_state_e st;
    ctrs_op_e op;
    ctrs_addr_t sp;
    ctrs_word_t w1;
    logic x_wr;
    ctrs_addr_t x_d;
    logic y_wr;
    ctrs_addr_t y_d;
    logic sp_wr;
    ctrs_addr_t sp_d;
    logic ccr_wr;
    ctrs_word_t ccr_d;
    logic pc_wr;
    ctrs_addr_t pc_d;
    logic call;
  } ctrs_state_s;

endpackage : ctrs_pkg

// ==== ctrs_adj_if.sv ====
/*
  Carrier between the sequencer and the 20-bit plus/minus two adjuster.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps

interface ctrs_adj_if;
  import ctrs_pkg::*;
  ctrs_addr_t value;
  logic dec;
  ctrs_addr_t result;
  modport user (output value, output dec, input result);
  modport unit (input value, input dec, output result);
endinterface : ctrs_adj_if

// ==== ctrs_adj20.sv ====
/*
  Adds or subtracts two on one full 20-bit extension:address quantity.
  Assumes a purely combinational use by its owner.
*/
`timescale 1ns/1ps
`include "ctrs_regs.svh"

module ctrs_adj20
  import ctrs_pkg::*;
(
  ctrs_adj_if.unit adj
);

  // =====================================================================
  // Carry and borrow run through the extension nibble
  always_comb
  begin
    if (adj.dec)
      adj.result = adj.value - `CTRS_ADJ_STEP;
    else
      adj.result = adj.value + `CTRS_ADJ_STEP;
  end

endmodule : ctrs_adj20

// ==== ctrs_exec_tb_top.sv ====
/*
  Self-checking bench of the transfer/return execution block: a table of
  back-to-back transfers and jumps, then returns, wait and reset by hand.
  Assumes the package, interface and design files are compiled first.
*/
`timescale 1ns/1ps

module ctrs_exec_tb_top
  import ctrs_pkg::*;
;
  // ===================================================================
  // Signals and design
  typedef struct {ctrs_op_e op; ctrs_mode_e md; ctrs_base_e bs; ctrs_addr_t opnd, sp, x, y, z;
    logic [4:0] mask; ctrs_addr_t dat; logic call;} ctrs_tb_row_s;
  logic sys_clk = 0, reset = 1, op_valid = 0, irq_pend = 0, mem_rd_valid = 0, in_ret = 0;
  ctrs_op_e op_code = CTRS_OP_NONE;
  ctrs_mode_e op_mode = CTRS_INDEXED_20BIT_MODE;
  ctrs_base_e op_base = CTRS_BASE_X;
  ctrs_addr_t op_operand = 20'h0_0000, sp_cur = 20'h0_0000, x_cur = 20'h0_0000;
  ctrs_addr_t y_cur = 20'h0_0000, z_cur = 20'h0_0000;
  ctrs_word_t mem_rd_data = 16'h0000;
  logic op_ready, mem_rd_req, waiting, x_wr, y_wr, sp_wr, ccr_wr, pc_wr, call_strobe;
  ctrs_addr_t mem_rd_addr, x_wr_data, y_wr_data, sp_wr_data, pc_wr_data;
  ctrs_word_t ccr_wr_data;
  int bad_count = 0, n_checks = 0, cyc = 0;
  ctrs_tb_row_s rows [11];

  ctrs_exec u_dut (.SYS_CLK(sys_clk), .RESET(reset), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_MODE(op_mode), .OP_BASE(op_base), .OP_OPERAND(op_operand), .SP_CUR(sp_cur), .X_CUR(x_cur),
    .Y_CUR(y_cur), .Z_CUR(z_cur), .IRQ_PEND(irq_pend), .MEM_RD_DATA(mem_rd_data),
    .MEM_RD_VALID(mem_rd_valid), .OP_READY(op_ready), .MEM_RD_REQ(mem_rd_req),
    .MEM_RD_ADDR(mem_rd_addr), .WAITING(waiting), .X_WR(x_wr), .X_WR_DATA(x_wr_data), .Y_WR(y_wr),
    .Y_WR_DATA(y_wr_data), .SP_WR(sp_wr), .SP_WR_DATA(sp_wr_data), .CCR_WR(ccr_wr),
    .CCR_WR_DATA(ccr_wr_data), .PC_WR(pc_wr), .PC_WR_DATA(pc_wr_data), .CALL_STROBE(call_strobe));

  // Clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // Returns never touch index registers
  always @(negedge sys_clk)
    if (in_ret) chk({x_wr, y_wr}, 20'h0_0000);

  // ===================================================================
  // Tasks
  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task set_row(input ctrs_tb_row_s r);
    op_valid = 1;
    op_code = r.op;
    op_mode = r.md;
    op_base = r.bs;
    op_operand = r.opnd;
    sp_cur = r.sp;
    x_cur = r.x;
    y_cur = r.y;
    z_cur = r.z;
  endtask : set_row

  task chk_row(input ctrs_tb_row_s r);
    ctrs_addr_t d;
    d = r.mask[4] ? x_wr_data : r.mask[3] ? y_wr_data : r.mask[2] ? sp_wr_data : pc_wr_data;
    chk({x_wr, y_wr, sp_wr, ccr_wr, pc_wr}, r.mask);
    chk(d, r.dat);
    chk(call_strobe, r.call);
  endtask : chk_row

  // Pop a frame at 0_FFFE with a slow first word and a prompt second one
  task do_ret(input ctrs_op_e op, input ctrs_word_t w1, input ctrs_word_t w2, input ctrs_addr_t pc,
              input logic [4:0] mask);
    in_ret = 1;
    op_valid = 1;
    op_code = op;
    sp_cur = 20'h0_FFFE;
    @(negedge sys_clk);
    op_valid = 0;
    chk({mem_rd_req, op_ready}, 20'h0_0002);
    chk(mem_rd_addr, 20'h0_FFFE);
    repeat (3) @(negedge sys_clk);
    chk(mem_rd_req, 20'h0_0001);
    mem_rd_valid = 1;
    mem_rd_data = w1;
    @(negedge sys_clk);
    chk(mem_rd_addr, 20'h1_0000);
    mem_rd_data = w2;
    @(negedge sys_clk);
    mem_rd_valid = 0;
    mem_rd_data = ~w2;
    in_ret = 0;
    chk({x_wr, y_wr, sp_wr, ccr_wr, pc_wr}, mask);
    chk(pc_wr_data, pc);
    chk(sp_wr_data, 20'h1_0002);
    chk(op_ready, 20'h0_0001);
  endtask : do_ret

  // ===================================================================
  // Main sequence
  initial
  begin
    rows[0] = '{CTRS_OP_STACK_TO_X_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'h0_FFFF,
      20'h0_0000, 20'h0_0000, 20'h0_0000, 5'h10, 20'h1_0001, 1'b0};
    rows[1] = '{CTRS_OP_STACK_TO_Y_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'hF_FFFF,
      20'h0_0000, 20'h0_0000, 20'h0_0000, 5'h08, 20'h0_0001, 1'b0};
    rows[2] = '{CTRS_OP_X_TO_STACK_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'h0_0000,
      20'h1_0000, 20'h0_0000, 20'h0_0000, 5'h04, 20'h0_FFFE, 1'b0};
    rows[3] = '{CTRS_OP_Y_TO_STACK_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'h0_0000,
      20'h0_0000, 20'h3_0001, 20'h0_0000, 5'h04, 20'h2_FFFF, 1'b0};
    rows[4] = '{CTRS_OP_X_TO_Y_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'h0_0000,
      20'hA_1234, 20'h0_0000, 20'h0_0000, 5'h08, 20'hA_1234, 1'b0};
    rows[5] = '{CTRS_OP_Y_TO_X_COPY, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0000, 20'h0_0000,
      20'h0_0000, 20'h5_ABCD, 20'h0_0000, 5'h10, 20'h5_ABCD, 1'b0};
    rows[6] = '{CTRS_OP_JUMP_OP, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_X, 20'h0_0020, 20'h0_0000,
      20'h1_FFF0, 20'h0_0100, 20'h0_0200, 5'h01, 20'h2_0010, 1'b0};
    rows[7] = '{CTRS_OP_CALL_OP, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_Y, 20'hF_FFF0, 20'h0_0000,
      20'h0_0300, 20'h0_8000, 20'h0_0200, 5'h01, 20'h0_7FF0, 1'b1};
    rows[8] = '{CTRS_OP_JUMP_OP, CTRS_INDEXED_20BIT_MODE, CTRS_BASE_Z, 20'h0_1111, 20'h0_0000,
      20'h0_0300, 20'h0_0100, 20'h4_4444, 5'h01, 20'h4_5555, 1'b0};
    rows[9] = '{CTRS_OP_JUMP_OP, CTRS_EXTENDED_20BIT_MODE, CTRS_BASE_X, 20'hC_DEF0, 20'h0_0000,
      20'h0_0300, 20'h0_0100, 20'h0_0200, 5'h01, 20'hC_DEF0, 1'b0};
    rows[10] = '{CTRS_OP_CALL_OP, CTRS_EXTENDED_20BIT_MODE, CTRS_BASE_Z, 20'h0_0102, 20'h0_0000,
      20'h0_0300, 20'h0_0100, 20'h0_0200, 5'h01, 20'h0_0102, 1'b1};
    // Reset values while held
    repeat (19) @(negedge sys_clk);
    chk({x_wr, y_wr, sp_wr, ccr_wr, pc_wr, call_strobe, waiting, mem_rd_req}, 20'h0_0000);
    chk(op_ready, 20'h0_0001);
    @(negedge sys_clk);
    reset = 0;
    $display("test reset done");
    // Table rows issued back to back
    foreach (rows[i])
    begin
      set_row(rows[i]);
      @(negedge sys_clk);
      chk_row(rows[i]);
    end
    op_valid = 0;
    @(negedge sys_clk);
    chk({x_wr, y_wr, sp_wr, ccr_wr, pc_wr, call_strobe}, 20'h0_0000);
    $display("test table done");
    // Returns
    do_ret(CTRS_OP_SUB_RETURN, 16'h0005, 16'h1234, 20'h5_1234, 5'h05);
    do_ret(CTRS_OP_INTERRUPT_RETURN, 16'hA5C7, 16'h0100, 20'h7_0100, 5'h07);
    chk(ccr_wr_data, 20'h0_A5C7);
    $display("test returns done");
    // Wait without timeout, then released by an interrupt
    op_valid = 1;
    op_code = CTRS_OP_WAIT_FOR_IRQ;
    @(negedge sys_clk);
    op_valid = 0;
    chk({waiting, op_ready}, 20'h0_0002);
    repeat (200) @(negedge sys_clk);
    chk({waiting, op_ready}, 20'h0_0002);
    irq_pend = 1;
    @(negedge sys_clk);
    chk({waiting, op_ready}, 20'h0_0001);
    // Interrupt already pending at accept
    op_valid = 1;
    @(negedge sys_clk);
    op_valid = 0;
    irq_pend = 0;
    chk({waiting, op_ready}, 20'h0_0001);
    // Reset ends a wait
    op_valid = 1;
    @(negedge sys_clk);
    op_valid = 0;
    chk(waiting, 20'h0_0001);
    reset = 1;
    #1;
    chk({waiting, op_ready}, 20'h0_0001);
    @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    chk({waiting, op_ready}, 20'h0_0001);
    $display("test wait done");
    complete_run();
  end

endmodule : ctrs_exec_tb_top
